// File: include/zcs_consts.svh
`ifndef ZCS_CONSTS_SVH
`define ZCS_CONSTS_SVH

// register byte offsets
`define ZCS_OFF_CONFIG 8'h00
`define ZCS_OFF_STATUS 8'h04
`define ZCS_OFF_RESULT0 8'h08
`define ZCS_OFF_RESULT1 8'h0C
`define ZCS_OFF_RESULT2 8'h10
`define ZCS_OFF_OVER0 8'h14
`define ZCS_OFF_HYST0 8'h18
`define ZCS_OFF_OVER1 8'h1C
`define ZCS_OFF_HYST1 8'h20
`define ZCS_OFF_OVER2 8'h24
`define ZCS_OFF_HYST2 8'h28

// configuration fields
`define ZCS_CFG_PD_BIT 0
`define ZCS_CFG_MODE_BIT 1
`define ZCS_CFG_FQ_LO 3
`define ZCS_CFG_FQ_HI 4
`define ZCS_CFG_IM_BIT 6
`define ZCS_CFG_WMASK 8'h5B
`define ZCS_CFG_RESET 8'h00

// status fields
`define ZCS_ST_ZONE_LO 0
`define ZCS_ST_ZONE_HI 1
`define ZCS_ST_ACTIVE_BIT 2
`define ZCS_ST_PAUSE_BIT 3
`define ZCS_ST_ADDR_BIT 4
`define ZCS_ST_CAPT_BIT 5
`define ZCS_ST_TRACK_LO 8
`define ZCS_ST_TRACK_HI 10
`define ZCS_ST_FQN_LO 12
`define ZCS_ST_FQN_HI 14

// zone numbers
`define ZCS_ZONE_LOCAL 2'h0
`define ZCS_ZONE_EXT1 2'h1
`define ZCS_ZONE_EXT2 2'h2

// threshold defaults, one degree per lsb
`define ZCS_OVER_LOCAL_RST 8'h51
`define ZCS_HYST_LOCAL_RST 8'h4C
`define ZCS_OVER_EXT_RST 8'h61
`define ZCS_HYST_EXT_RST 8'h5C
`define ZCS_TRACK_RST 3'h7
`define ZCS_RESULT_RST 8'h00

// filter depth codes and lengths
`define ZCS_FQ_1 2'h0
`define ZCS_FQ_2 2'h1
`define ZCS_FQ_4 2'h2
`define ZCS_FQ_LEN1 3'h1
`define ZCS_FQ_LEN2 3'h2
`define ZCS_FQ_LEN4 3'h4
`define ZCS_FQ_LEN6 3'h6

// timing: internal conversion time and clock period
`define ZCS_T_CONV_INT_US 40000
`define ZCS_CLK_PERIOD_NS 50
`define ZCS_SYNC_FILL 2'h3

`endif

// File: include/zcs_pkg.sv
package zcs_pkg;

  // sequencer states
  typedef enum logic [1:0] {
    ZCS_LAUNCH,
    ZCS_CONVERT,
    ZCS_PAUSE,
    ZCS_OFF
  } zcs_state_t;

  // zone number, 0 local, 1 and 2 remote
  typedef logic [1:0] zcs_zone_t;

  // 8-bit two's complement, one degree per lsb, bit 7 sign
  typedef logic [7:0] zcs_temp_t;

endpackage

// File: src/zcs_conv_timer.sv
`timescale 1ns/100ps
`default_nettype none

module zcs_conv_timer #(
  parameter int TIMER_W = 24
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic start,
  input wire logic abort,
  input wire logic [TIMER_W-1:0] length,
  output logic busy,
  output logic done
);

  logic [TIMER_W-1:0] count_reg;
  logic busy_reg;
  logic done_reg;

  generate
    if (TIMER_W < 2) begin : g_bad_width
      $error("zcs_conv_timer: TIMER_W must be at least 2");
    end
  endgenerate

  // count down the conversion; abort wins over start
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      count_reg <= '0;
      busy_reg <= 1'b0;
    end else if (abort) begin
      busy_reg <= 1'b0;
    end else if (start) begin
      count_reg <= length;
      busy_reg <= 1'b1;
    end else if (busy_reg) begin
      count_reg <= count_reg - 1'b1;
      if (count_reg == {{(TIMER_W-1){1'b0}}, 1'b1}) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // one-cycle completion pulse after the last count
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= busy_reg && !abort && !start && (count_reg == {{(TIMER_W-1){1'b0}}, 1'b1});
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;

  // a completion pulse lasts one cycle and leaves the timer idle in the next
  chk_done_single: assert property (@(posedge ref_clk) disable iff (srst)
    done |=> !done && !busy) // [RULE4]
    else $error("completion pulse lasted more than one cycle");

endmodule

`default_nettype wire

// File: src/zcs_sequencer.sv
// Overview of operation
// RULE1 - results are signed bytes, one degree
// RULE2 - convert continuously, pause during own transaction
// RULE3 - order is zone 1, zone 2, zone 0
// RULE4 - results ready after each zone period
// RULE5 - external conversion lasts twice internal
// RULE6 - interrupted conversion restarts, order continues
// RULE7 - cycle repeats until shutdown or transaction
// RULE8 - power-up loads every register default
// RULE9 - address pin sampled once at power-up
// RULE10 - power-up leaves device converting, not off
// RULE11 - alert mode defaults to comparator
// RULE12 - filter depth field defaults to 00
// RULE13 - alert mask defaults to zero
// RULE14 - local thresholds default 81 and 76
// RULE15 - remote thresholds default 97 and 92
// RULE16 - every zone armed for overtemperature first
// RULE17 - filter codes give 1, 2, 4, 6
// RULE18 - power-down stops; clearing restarts at zone 1
// RULE19 - result updates only on completed conversion
`timescale 1ns/100ps
`default_nettype none
`include "zcs_consts.svh"

module zcs_sequencer #(
  parameter int ADDR_W = 8,
  parameter int TIMER_W = 24,
  parameter int INT_CONV_CYCLES = (`ZCS_T_CONV_INT_US * 1000) / `ZCS_CLK_PERIOD_NS
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic address_select_pin,
  input wire logic bus_active,
  input wire logic [7:0] adc_sample,
  output logic [1:0] zone_select,
  output logic conv_active,
  output logic client_address_bit,
  output logic power_down_bit,
  output logic alert_mode,
  output logic alert_mask_bit,
  output logic [2:0] event_filter_count
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  generate
    if (ADDR_W < 8) begin : g_bad_addr
      $error("zcs_sequencer: ADDR_W must be at least 8");
    end
    if (INT_CONV_CYCLES < 1 || (2 * INT_CONV_CYCLES) >= (2 ** TIMER_W)) begin : g_bad_conv
      $error("zcs_sequencer: conversion length does not fit the timer");
    end
  endgenerate

  localparam logic [TIMER_W-1:0] INT_LEN = TIMER_W'(INT_CONV_CYCLES);
  localparam logic [TIMER_W-1:0] EXT_LEN = TIMER_W'(2 * INT_CONV_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // filter code to number of consecutive conversions
  function automatic logic [2:0] filter_len(input logic [1:0] code);
    unique case (code)
      `ZCS_FQ_1: filter_len = `ZCS_FQ_LEN1;
      `ZCS_FQ_2: filter_len = `ZCS_FQ_LEN2;
      `ZCS_FQ_4: filter_len = `ZCS_FQ_LEN4;
      default: filter_len = `ZCS_FQ_LEN6;
    endcase
  endfunction

  // zone that follows a finished conversion
  function automatic zcs_pkg::zcs_zone_t next_zone(input zcs_pkg::zcs_zone_t z);
    unique case (z)
      `ZCS_ZONE_EXT1: next_zone = `ZCS_ZONE_EXT2;
      `ZCS_ZONE_EXT2: next_zone = `ZCS_ZONE_LOCAL;
      default: next_zone = `ZCS_ZONE_EXT1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // storage

  logic [7:0] config_reg;
  zcs_pkg::zcs_temp_t zone_result_reg [3];
  zcs_pkg::zcs_temp_t over_limit_threshold_reg [3];
  zcs_pkg::zcs_temp_t hysteresis_threshold_reg [3];
  logic [2:0] track_over_reg;
  zcs_pkg::zcs_state_t state_reg;
  zcs_pkg::zcs_zone_t zone_reg;
  logic [2:0] addr_sync_reg;
  logic [1:0] fill_reg;
  logic addr_capt_reg;
  logic client_addr_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic timer_start;
  logic timer_abort;
  logic timer_busy;
  logic timer_done;
  logic [TIMER_W-1:0] conv_length;
  logic apb_setup;
  logic apb_write;
  logic [7:0] offs;
  logic addr_hi_zero;
  logic pd_cfg;

  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite && pready;
  assign offs = paddr[7:0];
  assign addr_hi_zero = (paddr >> 8) == '0;
  assign pd_cfg = config_reg[`ZCS_CFG_PD_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // address pin: three-stage sampler, caught once after reset release

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      addr_sync_reg <= 3'h0;
    end else begin
      addr_sync_reg <= {addr_sync_reg[1:0], address_select_pin};
    end
  end

  // wait for the sampler to fill, then latch once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fill_reg <= 2'h0;
      addr_capt_reg <= 1'b0;
      client_addr_reg <= 1'b0;
    end else if (fill_reg != `ZCS_SYNC_FILL) begin
      fill_reg <= fill_reg + 2'h1;
    end else if (!addr_capt_reg && (addr_sync_reg[1] == addr_sync_reg[2])) begin
      addr_capt_reg <= 1'b1; // [RULE9]
      client_addr_reg <= addr_sync_reg[2]; // [RULE9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: read data and error latched in setup, answered in access

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (apb_setup) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
      if (!addr_hi_zero) begin
        pslverr_reg <= 1'b1;
      end else begin
        unique case (offs)
          `ZCS_OFF_CONFIG: prdata_reg[7:0] <= config_reg;
          `ZCS_OFF_STATUS: begin
            prdata_reg[`ZCS_ST_ZONE_HI:`ZCS_ST_ZONE_LO] <= zone_reg;
            prdata_reg[`ZCS_ST_ACTIVE_BIT] <= timer_busy;
            prdata_reg[`ZCS_ST_PAUSE_BIT] <= (state_reg == zcs_pkg::ZCS_PAUSE);
            prdata_reg[`ZCS_ST_ADDR_BIT] <= client_addr_reg;
            prdata_reg[`ZCS_ST_CAPT_BIT] <= addr_capt_reg;
            prdata_reg[`ZCS_ST_TRACK_HI:`ZCS_ST_TRACK_LO] <= track_over_reg;
            prdata_reg[`ZCS_ST_FQN_HI:`ZCS_ST_FQN_LO] <=
              filter_len(config_reg[`ZCS_CFG_FQ_HI:`ZCS_CFG_FQ_LO]); // [RULE17]
          end
          `ZCS_OFF_RESULT0: prdata_reg[7:0] <= zone_result_reg[0];
          `ZCS_OFF_RESULT1: prdata_reg[7:0] <= zone_result_reg[1];
          `ZCS_OFF_RESULT2: prdata_reg[7:0] <= zone_result_reg[2];
          `ZCS_OFF_OVER0: prdata_reg[7:0] <= over_limit_threshold_reg[0];
          `ZCS_OFF_HYST0: prdata_reg[7:0] <= hysteresis_threshold_reg[0];
          `ZCS_OFF_OVER1: prdata_reg[7:0] <= over_limit_threshold_reg[1];
          `ZCS_OFF_HYST1: prdata_reg[7:0] <= hysteresis_threshold_reg[1];
          `ZCS_OFF_OVER2: prdata_reg[7:0] <= over_limit_threshold_reg[2];
          `ZCS_OFF_HYST2: prdata_reg[7:0] <= hysteresis_threshold_reg[2];
          default: pslverr_reg <= 1'b1;
        endcase
      end
    end
  end

  // access phase always completes in its first cycle
  assign pready = psel && penable;
  assign prdata = prdata_reg;
  assign pslverr = pready && pslverr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // configuration register, defaults loaded at reset

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      config_reg <= `ZCS_CFG_RESET; // [RULE8] [RULE10] [RULE11] [RULE12] [RULE13]
    end else if (apb_write && !pslverr_reg && offs == `ZCS_OFF_CONFIG) begin
      config_reg <= pwdata[7:0] & `ZCS_CFG_WMASK;
    end
  end

  // thresholds: local and remote defaults, writable over apb
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      over_limit_threshold_reg[0] <= `ZCS_OVER_LOCAL_RST; // [RULE14]
      hysteresis_threshold_reg[0] <= `ZCS_HYST_LOCAL_RST; // [RULE14]
      for (int i = 1; i < 3; i++) begin
        over_limit_threshold_reg[i] <= `ZCS_OVER_EXT_RST; // [RULE15]
        hysteresis_threshold_reg[i] <= `ZCS_HYST_EXT_RST; // [RULE15]
      end
    end else if (apb_write && !pslverr_reg) begin
      unique case (offs)
        `ZCS_OFF_OVER0: over_limit_threshold_reg[0] <= pwdata[7:0];
        `ZCS_OFF_HYST0: hysteresis_threshold_reg[0] <= pwdata[7:0];
        `ZCS_OFF_OVER1: over_limit_threshold_reg[1] <= pwdata[7:0];
        `ZCS_OFF_HYST1: hysteresis_threshold_reg[1] <= pwdata[7:0];
        `ZCS_OFF_OVER2: over_limit_threshold_reg[2] <= pwdata[7:0];
        `ZCS_OFF_HYST2: hysteresis_threshold_reg[2] <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // event tracking starts armed for overtemperature on every zone
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      track_over_reg <= `ZCS_TRACK_RST; // [RULE16]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer

  // external zones take twice the internal length
  assign conv_length = (zone_reg == `ZCS_ZONE_LOCAL) ? INT_LEN : EXT_LEN; // [RULE5]
  assign timer_start = (state_reg == zcs_pkg::ZCS_LAUNCH) && !pd_cfg && !bus_active;
  assign timer_abort = (state_reg == zcs_pkg::ZCS_CONVERT) && (pd_cfg || bus_active);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= zcs_pkg::ZCS_LAUNCH; // [RULE10]
      zone_reg <= `ZCS_ZONE_EXT1; // [RULE3]
    end else begin
      unique case (state_reg)
        zcs_pkg::ZCS_LAUNCH: begin
          if (pd_cfg) begin
            state_reg <= zcs_pkg::ZCS_OFF;
          end else if (bus_active) begin
            state_reg <= zcs_pkg::ZCS_PAUSE; // [RULE2]
          end else begin
            state_reg <= zcs_pkg::ZCS_CONVERT; // [RULE2]
          end
        end
        zcs_pkg::ZCS_CONVERT: begin
          if (pd_cfg) begin
            state_reg <= zcs_pkg::ZCS_OFF; // [RULE18]
          end else if (bus_active) begin
            state_reg <= zcs_pkg::ZCS_PAUSE; // [RULE6]
          end else if (timer_done) begin
            zone_reg <= next_zone(zone_reg); // [RULE3] [RULE7]
            state_reg <= zcs_pkg::ZCS_LAUNCH; // [RULE7]
          end
        end
        zcs_pkg::ZCS_PAUSE: begin
          if (pd_cfg) begin
            state_reg <= zcs_pkg::ZCS_OFF;
          end else if (!bus_active) begin
            state_reg <= zcs_pkg::ZCS_LAUNCH; // [RULE6]
          end
        end
        zcs_pkg::ZCS_OFF: begin
          zone_reg <= `ZCS_ZONE_EXT1; // [RULE18]
          if (!pd_cfg) begin
            state_reg <= zcs_pkg::ZCS_LAUNCH; // [RULE18]
          end
        end
      endcase
    end
  end

  // store a result only when its conversion really finished
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int i = 0; i < 3; i++) begin
        zone_result_reg[i] <= `ZCS_RESULT_RST; // [RULE8]
      end
    end else if (state_reg == zcs_pkg::ZCS_CONVERT && timer_done && !pd_cfg && !bus_active) begin
      zone_result_reg[zone_reg] <= adc_sample; // [RULE1] [RULE4] [RULE19]
    end
  end

  zcs_conv_timer #(
    .TIMER_W(TIMER_W)
  ) u_timer (
    .ref_clk(ref_clk),
    .srst(srst),
    .start(timer_start),
    .abort(timer_abort),
    .length(conv_length),
    .busy(timer_busy),
    .done(timer_done)
  );

  // outputs
  assign zone_select = zone_reg;
  assign conv_active = timer_busy;
  assign client_address_bit = client_addr_reg;
  assign power_down_bit = pd_cfg;
  assign alert_mode = config_reg[`ZCS_CFG_MODE_BIT];
  assign alert_mask_bit = config_reg[`ZCS_CFG_IM_BIT];
  assign event_filter_count = filter_len(config_reg[`ZCS_CFG_FQ_HI:`ZCS_CFG_FQ_LO]); // [RULE17]

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_finish;
    state_reg == zcs_pkg::ZCS_CONVERT && timer_done && !pd_cfg && !bus_active;
  endsequence

  sequence s_interrupt;
    state_reg == zcs_pkg::ZCS_CONVERT && bus_active && !pd_cfg;
  endsequence

  chk_result_hold: assert property (@(posedge ref_clk) disable iff (srst) // [RULE19]
    !$past(state_reg == zcs_pkg::ZCS_CONVERT && timer_done) |->
      $stable(zone_result_reg[0]) && $stable(zone_result_reg[1]) && $stable(zone_result_reg[2]))
    else $error("result changed without a finished conversion");

  chk_result_value: assert property (@(posedge ref_clk) disable iff (srst) // [RULE1]
    s_finish |=> zone_result_reg[$past(zone_reg)] == $past(adc_sample))
    else $error("stored result differs from the converted byte");

  chk_zone_order: assert property (@(posedge ref_clk) disable iff (srst) // [RULE3]
    s_finish and (zone_reg == `ZCS_ZONE_EXT1) |=> zone_reg == `ZCS_ZONE_EXT2)
    else $error("zone 2 did not follow zone 1");

  chk_cycle_wrap: assert property (@(posedge ref_clk) disable iff (srst) // [RULE7]
    s_finish and (zone_reg == `ZCS_ZONE_LOCAL) |=> zone_reg == `ZCS_ZONE_EXT1
      ##1 (timer_busy || state_reg != zcs_pkg::ZCS_CONVERT))
    else $error("sequence did not wrap back to zone 1");

  chk_length_ratio: assert property (@(posedge ref_clk) disable iff (srst) // [RULE5]
    timer_start |-> conv_length == ((zone_reg == `ZCS_ZONE_LOCAL) ? INT_LEN : (INT_LEN << 1)))
    else $error("conversion length ratio wrong");

  chk_pause_bus: assert property (@(posedge ref_clk) disable iff (srst) // [RULE2]
    s_interrupt |=> state_reg == zcs_pkg::ZCS_PAUSE && !timer_busy)
    else $error("conversion did not pause for a transaction");

  chk_redo_zone: assert property (@(posedge ref_clk) disable iff (srst) // [RULE6]
    state_reg == zcs_pkg::ZCS_PAUSE && !bus_active && !pd_cfg |=>
      $stable(zone_reg) ##1 (timer_busy || state_reg != zcs_pkg::ZCS_CONVERT))
    else $error("interrupted zone was not restarted");

  chk_power_down: assert property (@(posedge ref_clk) disable iff (srst) // [RULE18]
    pd_cfg |=> state_reg == zcs_pkg::ZCS_OFF ##1 (!pd_cfg or !timer_busy))
    else $error("power-down did not stop conversions");

  chk_wake_zone1: assert property (@(posedge ref_clk) disable iff (srst) // [RULE18]
    state_reg == zcs_pkg::ZCS_OFF && !pd_cfg |=> zone_reg == `ZCS_ZONE_EXT1 && state_reg == zcs_pkg::ZCS_LAUNCH)
    else $error("wake from power-down not at zone 1");

  chk_addr_once: assert property (@(posedge ref_clk) disable iff (srst) // [RULE9]
    addr_capt_reg |=> addr_capt_reg && $stable(client_addr_reg))
    else $error("client address changed after capture");

  chk_reset_defaults: assert property (@(posedge ref_clk) // [RULE14]
    $past(srst) |-> config_reg == `ZCS_CFG_RESET && over_limit_threshold_reg[0] == `ZCS_OVER_LOCAL_RST
      && hysteresis_threshold_reg[2] == `ZCS_HYST_EXT_RST && track_over_reg == `ZCS_TRACK_RST
      && state_reg == zcs_pkg::ZCS_LAUNCH)
    else $error("power-up defaults not loaded");

endmodule

`default_nettype wire

// File: tb/zcs_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// far-side serial host: holds a transaction addressing the device for len cycles
module zcs_host_model (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic go,
  input wire logic [7:0] len,
  output logic bus_active
);
  logic [7:0] busy_reg;

  // transaction length counter, bus idle when it reaches zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busy_reg <= 8'h00;
    end else if (go) begin
      busy_reg <= len;
    end else if (busy_reg != 8'h00) begin
      busy_reg <= busy_reg - 8'h01;
    end
  end

  assign bus_active = (busy_reg != 8'h00);
endmodule

`default_nettype wire

// File: tb/zone_conversion_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "zcs_consts.svh"

`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end

module zone_conversion_sequencer_tb;
  localparam int INT = 20;
  logic ref_clk, srst, psel, penable, pwrite, addr_pin, go, bus_active, pslverr, pready, err;
  logic [7:0] paddr, adc_sample, len;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] zone_select;
  logic conv_active, client_address_bit, power_down_bit, alert_mode, alert_mask_bit;
  logic [2:0] event_filter_count;
  logic [7:0] adc_tab [3];
  int n_fail, total_checks, n0, n1, n2, k;
  logic [1:0] z;

  zcs_sequencer #(.INT_CONV_CYCLES(INT)) zcs_sequencer_i (.ref_clk(ref_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .address_select_pin(addr_pin), .bus_active(bus_active), .adc_sample(adc_sample),
    .zone_select(zone_select), .conv_active(conv_active), .client_address_bit(client_address_bit),
    .power_down_bit(power_down_bit), .alert_mode(alert_mode), .alert_mask_bit(alert_mask_bit),
    .event_filter_count(event_filter_count));
  zcs_host_model zcs_host_model_i (.ref_clk(ref_clk), .srst(srst), .go(go), .len(len), .bus_active(bus_active));

  // clock at 20 MHz
  always #25 ref_clk = ~ref_clk;

  // converter byte follows the zone being converted
  always @(posedge ref_clk) adc_sample <= adc_tab[zone_select];

  ////////////////////////////////////////////////////////////////////////////////
  // bus cycle: setup, then access until pready is seen at a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // waits for a conversion, reports its zone and how long it ran
  task conv_len(output int n, output logic [1:0] zn);
    n = 0;
    do begin
      @(posedge ref_clk);
    end while (conv_active !== 1'b1);
    zn = zone_select;
    while (conv_active === 1'b1) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults;
    logic [7:0] adr [10] = '{8'h08, 8'h0C, 8'h10, 8'h00, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28};
    logic [7:0] exp [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h51, 8'h4C, 8'h61, 8'h5C, 8'h61, 8'h5C};
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, adr[i], 32'h0000_0000, rd);
      `CHK("reset register", {24'h00_0000, exp[i]}, rd)
    end
    `CHK("power down out", 1'b0, power_down_bit)
    `CHK("alert mode out", 1'b0, alert_mode)
    `CHK("alert mask out", 1'b0, alert_mask_bit)
    `CHK("filter count", 3'h1, event_filter_count)
    apb(1'b0, 8'h04, 32'h0000_0000, rd);
    `CHK("armed over", 3'h7, rd[10:8])
    `CHK("address captured", 2'h3, rd[5:4])
  endtask

  task t_order;
    conv_len(n1, z);
    `CHK("first zone", 2'h1, z)
    conv_len(n2, z);
    `CHK("second zone", 2'h2, z)
    conv_len(n0, z);
    `CHK("third zone", 2'h0, z)
    `CHK("local length", INT, n0)
    conv_len(k, z);
    `CHK("cycle repeats", 2'h1, z)
    `CHK("remote lengths", n2, k)
    `CHK("remote minus local", INT, k - n0)
    apb(1'b0, 8'h08, 32'h0000_0000, rd);
    `CHK("zone0 result", 32'h0000_00FF, rd)
    apb(1'b0, 8'h0C, 32'h0000_0000, rd);
    `CHK("zone1 result", 32'h0000_00E7, rd)
    apb(1'b0, 8'h10, 32'h0000_0000, rd);
    `CHK("zone2 result", 32'h0000_0019, rd)
  endtask

  task t_interrupt;
    while (!(zone_select === 2'h2 && conv_active === 1'b1)) begin
      @(posedge ref_clk);
    end
    adc_tab[2] = 8'hC9;
    repeat (4) @(posedge ref_clk);
    go <= 1'b1; len <= 8'd12;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK("paused by bus", 1'b0, conv_active)
    apb(1'b0, 8'h10, 32'h0000_0000, rd);
    `CHK("result kept", 32'h0000_0019, rd)
    conv_len(k, z);
    `CHK("redone zone", 2'h2, z)
    `CHK("redone length", n2, k)
    conv_len(k, z);
    `CHK("order resumes", 2'h0, z)
    apb(1'b0, 8'h10, 32'h0000_0000, rd);
    `CHK("new zone2 result", 32'h0000_00C9, rd)
  endtask

  task t_power_down;
    apb(1'b1, 8'h00, 32'h0000_0001, rd);
    repeat (3) @(posedge ref_clk);
    `CHK("power down out", 1'b1, power_down_bit)
    k = 0;
    repeat (60) begin
      @(posedge ref_clk);
      if (conv_active !== 1'b0) k++;
    end
    `CHK("no conversions", 0, k)
    apb(1'b1, 8'h00, 32'h0000_0000, rd);
    conv_len(k, z);
    `CHK("restart zone", 2'h1, z)
  endtask

  task automatic t_config;
    logic [2:0] depth [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h00, {27'h0, i[1:0], 3'h0}, rd);
      @(posedge ref_clk);
      `CHK("filter depth", depth[i], event_filter_count)
    end
    apb(1'b1, 8'h00, 32'h0000_00FE, rd);
    apb(1'b0, 8'h00, 32'h0000_0000, rd);
    `CHK("config mask", 32'h0000_005A, rd)
    apb(1'b0, 8'h2C, 32'h0000_0000, rd);
    `CHK("unmapped error", 1'b1, err)
    addr_pin <= 1'b0;
    repeat (8) @(posedge ref_clk);
    `CHK("address held", 1'b1, client_address_bit)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // watchdog sized well above the expected run
  initial begin
    #(50 * 20000);
    n_fail++;
    wrap_up();
  end

  // main sequence
  initial begin
    ref_clk = 1'b0; srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0000_0000; addr_pin = 1'b1; go = 1'b0; len = 8'h00; adc_sample = 8'h00;
    adc_tab = '{8'hFF, 8'hE7, 8'h19};
    n_fail = 0; total_checks = 0;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    t_defaults();
    t_order();
    t_interrupt();
    t_power_down();
    t_config();
    wrap_up();
  end
endmodule

`default_nettype wire
